// ==== verilog/dcpw_unit.sv ====
`timescale 1ns/1ns
module dcpw_unit (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Configuration and control
  input  wire logic       port_reset_high_option,
  input  wire logic       modulator_run,
  input  wire logic       counter_clear,
  input  wire logic [1:0] clock_source_select,
  input  wire logic [1:0] prescale_select,
  input  wire logic [7:0] channel_compare_value_0,
  input  wire logic [7:0] channel_compare_value_1,
  input  wire logic       channel_output_enable_0,
  input  wire logic       channel_output_enable_1,
  // Timer overflow pulses, same clock domain
  input  wire logic       timer0_overflow,
  input  wire logic       timer1_overflow,
  // Ordinary port latch levels used while a channel is disabled
  input  wire logic       port_latch_0,
  input  wire logic       port_latch_1,
  // Pins and status
  output logic            channel_zero_output,
  output logic            channel_one_output,
  output logic [7:0]      counter_value
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // The reset-high option is a strap, caught once after reset release.
  logic strap_done_q, strap_done_d;
  logic reset_high_q, reset_high_d;

  always_comb begin
    strap_done_d = 1'b1;
    reset_high_d = strap_done_q ? reset_high_q : port_reset_high_option;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      reset_high_q <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
      reset_high_q <= reset_high_d;
    end
  end

  // ----------------------------------------------------------------
  // Clock source and prescaler
  // ----------------------------------------------------------------
  logic       src_tick;
  logic [2:0] pre_q, pre_d;
  logic       adv;
  logic [2:0] pre_mask;

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction : div_mask

  always_comb begin
    case (clock_source_select)
      dcpw_pkg::SRC_CPU: src_tick = 1'b1;
      dcpw_pkg::SRC_T0:  src_tick = timer0_overflow;
      dcpw_pkg::SRC_T1:  src_tick = timer1_overflow;
      default:           src_tick = 1'b0;
    endcase
    pre_mask = div_mask(prescale_select);
    adv   = modulator_run && src_tick && ((pre_q & pre_mask) == pre_mask);
    pre_d = pre_q;
    // Clearing while idle keeps the prescaler phase, so a restart resumes mid-division.
    if (counter_clear || !modulator_run) begin
      pre_d = modulator_run ? dcpw_pkg::PRE_RESET : pre_q;
    end else if (src_tick) begin
      pre_d = 3'((pre_q + 3'h1) & pre_mask);
    end
  end

  // ----------------------------------------------------------------
  // Shared counter and compare buffers
  // ----------------------------------------------------------------
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] buf_q [2];
  logic [7:0] buf_d [2];
  logic       ovf;
  logic [7:0] cmp_in [2];

  assign cmp_in[0] = channel_compare_value_0;
  assign cmp_in[1] = channel_compare_value_1;

  always_comb begin
    ovf   = adv && (cnt_q == dcpw_pkg::CNT_MAX);
    cnt_d = cnt_q;
    if (counter_clear) begin
      cnt_d = dcpw_pkg::CNT_RESET;
    end else if (adv) begin
      cnt_d = 8'(cnt_q + 8'h01);
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      buf_d[i] = ovf ? cmp_in[i] : buf_q[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= dcpw_pkg::CNT_RESET;
      pre_q    <= dcpw_pkg::PRE_RESET;
      buf_q[0] <= dcpw_pkg::CMP_ALL_ZERO;
      buf_q[1] <= dcpw_pkg::CMP_ALL_ZERO;
    end else begin
      cnt_q    <= cnt_d;
      pre_q    <= pre_d;
      buf_q[0] <= buf_d[0];
      buf_q[1] <= buf_d[1];
    end
  end

  // ----------------------------------------------------------------
  // Channel levels
  // ----------------------------------------------------------------
  logic [1:0] lvl_q, lvl_d;
  logic [1:0] pin_q, pin_d;
  logic [1:0] oe;
  logic [1:0] latch;

  assign oe    = {channel_output_enable_1, channel_output_enable_0};
  assign latch = {port_latch_1, port_latch_0};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lvl_d[i] = lvl_q[i];
      if (adv) begin
        if (buf_d[i] == dcpw_pkg::CMP_ALL_ONE) begin
          lvl_d[i] = 1'b0;
        end else if (buf_d[i] == dcpw_pkg::CMP_ALL_ZERO) begin
          lvl_d[i] = 1'b1;
        end else begin
          lvl_d[i] = (cnt_d < buf_d[i]);
        end
      end
      // hold level while idle; after strap capture lvl_q is only updated on advance.
      // disabled channel shows the port latch
      pin_d[i] = oe[i] ? lvl_q[i] : latch[i];
      if (!strap_done_q) begin
        pin_d[i] = reset_high_d;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 2'h3;
      pin_q <= 2'h0;
    end else begin
      lvl_q <= strap_done_q ? lvl_d : {2{reset_high_d}};
      pin_q <= pin_d;
    end
  end

  logic [7:0] cntout_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cntout_q <= dcpw_pkg::CNT_RESET;
    end else begin
      cntout_q <= cnt_d;
    end
  end

  assign channel_zero_output = pin_q[0];
  assign channel_one_output  = pin_q[1];
  assign counter_value       = cntout_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_clear_zeroes_count: assert property (@(posedge mclk) disable iff (!rst_n)
    counter_clear |=> cnt_q == 8'h00)
    else $error("counter not cleared");
  a_idle_holds_count: assert property (@(posedge mclk) disable iff (!rst_n)
    (!modulator_run && !counter_clear) |=> $stable(cnt_q))
    else $error("counter moved while idle");
  a_wrap_to_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (ovf && !counter_clear) |=> cnt_q == 8'h00)
    else $error("counter did not wrap");
  a_buffer_at_ovf: assert property (@(posedge mclk) disable iff (!rst_n)
    !ovf |=> $stable(buf_q[0]) && $stable(buf_q[1]))
    else $error("buffer changed off overflow");
  a_idle_holds_level: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && !modulator_run) |=> $stable(lvl_q))
    else $error("level changed while idle");
  a_ones_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && adv && buf_d[0] == 8'hff) |=> !lvl_q[0])
    else $error("all ones not low");
  a_zeroes_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && adv && buf_d[1] == 8'h00) |=> lvl_q[1])
    else $error("all zeroes not high");
  a_match_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && adv && buf_d[0] != 8'h00 && cnt_d == buf_d[0]) |=> !lvl_q[0])
    else $error("match did not drive low");
  a_pin_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && !oe[0]) |=> channel_zero_output == $past(latch[0]))
    else $error("disabled pin not port level");
  a_cpu_every_edge: assert property (@(posedge mclk) disable iff (!rst_n)
    (modulator_run && !counter_clear && clock_source_select == 2'h0
     && prescale_select == 2'h0) |=> cnt_q == 8'($past(cnt_q) + 8'h01))
    else $error("cpu source did not advance");

  // Other-channel mirrors, so both generators are watched alike.
  a_ones1_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && adv && buf_d[1] == 8'hff) |=> !lvl_q[1])
    else $error("all ones not low on channel one");
  a_zeroes0_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && adv && buf_d[0] == 8'h00) |=> lvl_q[0])
    else $error("all zeroes not high on channel zero");
  a_match1_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && adv && buf_d[1] != 8'h00 && cnt_d == buf_d[1]) |=> !lvl_q[1])
    else $error("match did not drive channel one low");
  a_pin1_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && !oe[1]) |=> channel_one_output == $past(latch[1]))
    else $error("disabled pin one not port level");

  // A wrap returns every channel high unless its buffer is all ones.
  a_wrap_high0: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && ovf && buf_d[0] != 8'hff) |=> lvl_q[0])
    else $error("channel zero not high after overflow");
  a_wrap_high1: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && ovf && buf_d[1] != 8'hff) |=> lvl_q[1])
    else $error("channel one not high after overflow");
  a_pin0_level: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && oe[0]) |=> channel_zero_output == $past(lvl_q[0]))
    else $error("enabled pin zero not modulated level");
  a_pin1_level: assert property (@(posedge mclk) disable iff (!rst_n)
    (strap_done_q && oe[1]) |=> channel_one_output == $past(lvl_q[1]))
    else $error("enabled pin one not modulated level");

  // Strap capture: the first level after reset and its later stability.
  a_strap_level: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(strap_done_q) |-> (lvl_q == {2{reset_high_q}} && channel_zero_output == reset_high_q
      && channel_one_output == reset_high_q))
    else $error("reset level does not follow strap");
  a_strap_held: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_done_q |=> $stable(reset_high_q))
    else $error("strap level changed after capture");

  // Source, prescaler and buffer bookkeeping.
  a_no_source: assert property (@(posedge mclk) disable iff (!rst_n)
    (clock_source_select == 2'h3 && !counter_clear) |=> $stable(cnt_q))
    else $error("counter moved with no source");
  a_pre_holds: assert property (@(posedge mclk) disable iff (!rst_n)
    (!src_tick && !counter_clear) |=> $stable(pre_q) && $stable(cnt_q))
    else $error("prescaler moved without a source tick");
  a_count_copy: assert property (@(posedge mclk) disable iff (!rst_n)
    counter_value == cnt_q)
    else $error("counter output differs from counter");
  a_ovf_loads: assert property (@(posedge mclk) disable iff (!rst_n)
    ovf |=> (buf_q[0] == $past(channel_compare_value_0)
      && buf_q[1] == $past(channel_compare_value_1)))
    else $error("buffer not loaded at overflow");
  a_clear_pre: assert property (@(posedge mclk) disable iff (!rst_n)
    (counter_clear && modulator_run) |=> pre_q == dcpw_pkg::PRE_RESET)
    else $error("prescaler not cleared");

endmodule : dcpw_unit

// ==== verilog/dcpw_pkg.sv ====
package dcpw_pkg;

  // ----------------------------------------------------------------
  // Field widths and encodings
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned SEL_W         = 2;
  localparam logic [1:0]  SRC_CPU       = 2'h0;
  localparam logic [1:0]  SRC_T0        = 2'h1;
  localparam logic [1:0]  SRC_T1        = 2'h2;
  localparam logic [7:0]  CNT_MAX       = 8'hff;
  localparam logic [7:0]  CMP_ALL_ZERO  = 8'h00;
  localparam logic [7:0]  CMP_ALL_ONE   = 8'hff;
  localparam logic [7:0]  CNT_RESET     = 8'h00;
  localparam logic [2:0]  PRE_RESET     = 3'h0;

endpackage : dcpw_pkg

// ==== sim/dcpw_load.sv ====
`timescale 1ns/1ns
// Loads on both pins; each counts the edges its pin spends low until cleared.
module dcpw_load (
  // Clock and count control
  input  wire logic        mclk,
  input  wire logic        clr,
  // Pins
  input  wire logic        pin_0,
  input  wire logic        pin_1,
  // Low-time counts
  output logic      [15:0] low_0,
  output logic      [15:0] low_1
);
  // An unknown pin level turns the count unknown, so it cannot pass unseen.
  always_ff @(posedge mclk) begin
    low_0 <= clr ? 16'h0 : low_0 + {15'h0, ~pin_0};
    low_1 <= clr ? 16'h0 : low_1 + {15'h0, ~pin_1};
  end
endmodule : dcpw_load

// ==== sim/test_dcpw_unit.sv ====
`timescale 1ns/1ns
module test_dcpw_unit;
  typedef struct {
    logic [7:0]  c0;
    logic [7:0]  c1;
    logic [1:0]  src;
    logic [1:0]  pre;
    logic [15:0] per;
    logic [15:0] l0;
    logic [15:0] l1;
  } dcpw_row_s;
  logic        mclk = 1'b0, resetn = 1'b0, strap = 1'b1, run = 1'b0, clear = 1'b0;
  logic        t0 = 1'b0, t1 = 1'b0, oe0 = 1'b1, oe1 = 1'b1, lat0 = 1'b0, lat1 = 1'b0;
  logic        clr = 1'b0, pin0, pin1;
  logic [1:0]  src = 2'h0, pre = 2'h0;
  logic [7:0]  cmp0 = 8'h00, cmp1 = 8'h00, cnt, v;
  logic [15:0] low0, low1, per;
  int          bad_count = 0, checked = 0, cyc = 0;
  dcpw_row_s   rows [5] = '{
    '{8'h00, 8'hff, 2'h0, 2'h0, 16'h0100, 16'h0000, 16'h0100},
    '{8'h01, 8'hfe, 2'h0, 2'h1, 16'h0200, 16'h01fe, 16'h0004},
    '{8'h80, 8'h40, 2'h1, 2'h2, 16'h0800, 16'h0400, 16'h0600},
    '{8'hc0, 8'h20, 2'h2, 2'h3, 16'h1800, 16'h0600, 16'h1500},
    '{8'hff, 8'h00, 2'h0, 2'h0, 16'h0100, 16'h0100, 16'h0000}};

  dcpw_unit i_dut (.mclk(mclk), .resetn(resetn), .port_reset_high_option(strap),
    .modulator_run(run), .counter_clear(clear), .clock_source_select(src),
    .prescale_select(pre), .channel_compare_value_0(cmp0),
    .channel_compare_value_1(cmp1), .channel_output_enable_0(oe0),
    .channel_output_enable_1(oe1), .timer0_overflow(t0), .timer1_overflow(t1),
    .port_latch_0(lat0), .port_latch_1(lat1), .channel_zero_output(pin0),
    .channel_one_output(pin1), .counter_value(cnt));
  dcpw_load i_load (.mclk(mclk), .clr(clr), .pin_0(pin0), .pin_1(pin1),
    .low_0(low0), .low_1(low1));

  initial forever #10 mclk = ~mclk;
  // Timer 0 ticks every 2nd cycle and timer 1 every 3rd, so each source has its own rate.
  always @(posedge mclk) begin
    #2;
    cyc++;
    t0 = (cyc % 2 == 0);
    t1 = (cyc % 3 == 0);
    if (cyc == 90000) begin
      bad_count++;
      conclude();
    end
  end

  task step(int n);
    repeat (n) begin
      @(posedge mclk);
      #2;
    end
  endtask : step
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wait_wrap(output logic [15:0] n);
    logic [7:0] prev;
    n = 16'h0;
    do begin
      prev = cnt;
      step(1);
      n = n + 16'h1;
    end while (!(prev === 8'hff && cnt === 8'h00) && n < 16'd8000);
  endtask : wait_wrap
  // The window spans exactly one period, so the fixed pin lag does not matter.
  task measure;
    wait_wrap(per);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    wait_wrap(per);
    // The edge spent on the count clear is part of the period too.
    per = per + 16'h1;
    step(1);
  endtask : measure
  task conclude;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    step(2);
    resetn = 1'b1;
    step(6);
    check("pin0 reset high", {15'h0, pin0}, 16'h1);
    check("pin1 reset high", {15'h0, pin1}, 16'h1);
    resetn = 1'b0;
    strap = 1'b0;
    step(2);
    resetn = 1'b1;
    step(6);
    check("pin0 reset low", {15'h0, pin0}, 16'h0);
    check("pin1 reset low", {15'h0, pin1}, 16'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      {oe0, oe1} = 2'b00;
      {cmp0, cmp1, src, pre} = {rows[i].c0, rows[i].c1, rows[i].src, rows[i].pre};
      {run, clear} = 2'b11;
      step(1);
      clear = 1'b0;
      // enables come last
      // Outputs are enabled only after the channels are loaded and running.
      {oe0, oe1} = 2'b11;
      measure;
      check("period", per, rows[i].per);
      check("low0", low0, rows[i].l0);
      check("low1", low1, rows[i].l1);
      $display("test row %0d done", i);
    end
    src = 2'h3;
    step(3);
    v = cnt;
    step(20);
    check("no source", {8'h0, cnt}, {8'h0, v});
    {src, pre, cmp0, cmp1} = {2'h0, 2'h0, 8'h80, 8'hc0};
    wait_wrap(per);
    measure;
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(50);
    // A mid-period change must not shorten or stretch the current pulse.
    cmp0 = 8'h10;
    wait_wrap(per);
    step(1);
    check("buffered low0", low0, 16'h0080);
    check("buffered low1", low1, 16'h0040);
    step(150);
    run = 1'b0;
    step(3);
    v = cnt;
    step(30);
    check("idle count", {8'h0, cnt}, {8'h0, v});
    check("idle pin0", {15'h0, pin0}, 16'h0);
    check("idle pin1", {15'h0, pin1}, 16'h1);
    clear = 1'b1;
    step(1);
    clear = 1'b0;
    step(2);
    check("cleared", {8'h0, cnt}, 16'h0);
    $display("test idle done");
    {oe0, oe1} = 2'b00;
    for (int b = 0; b < 2; b++) begin
      {lat0, lat1} = {b[0], ~b[0]};
      step(3);
      check("latch pin0", {15'h0, pin0}, {15'h0, b[0]});
      check("latch pin1", {15'h0, pin1}, {15'h0, ~b[0]});
    end
    $display("test port done");
    conclude();
  end
endmodule : test_dcpw_unit
